// >>> inc/ascp_map.vh
`ifndef ASCP_MAP_VH
`define ASCP_MAP_VH
// ----------------------------------------
// Command byte fields
// ----------------------------------------
`define ASCP_BIT_START 7
`define ASCP_BIT_POL 6
`define ASCP_BIT_CLKSRC 5
`define ASCP_BIT_MODE_HI 4
`define ASCP_BIT_MODE_LO 3
`define ASCP_BIT_GP2 2
`define ASCP_BIT_GP1 1
`define ASCP_BIT_GP0 0
`define ASCP_MODE_SHORT 2'h0
`define ASCP_MODE_CAL 2'h1
`define ASCP_MODE_PDOWN 2'h2
`define ASCP_MODE_LONG 2'h3
// ----------------------------------------
// Reset values
// ----------------------------------------
`define ASCP_GP_RESET 3'h0
`define ASCP_POL_RESET 1'h0
`define ASCP_CLKSRC_RESET 1'h1
// ----------------------------------------
// Timing
// ----------------------------------------
`define ASCP_CLK_MHZ 20
`define ASCP_CONV_MAX_US 6
`define ASCP_CONV_CYCLES (`ASCP_CONV_MAX_US * `ASCP_CLK_MHZ)
`define ASCP_SHORT_CLOCKS 24
`define ASCP_LONG_CLOCKS 32
`define ASCP_STROBE_SHORT_EDGE 6'h07
`define ASCP_STROBE_LONG_EDGE 6'h0f
`define ASCP_RESULT_BITS 16
`endif

// >>> verification/ascp_host.sv
`timescale 1ns/1ns
module ascp_host (
   input wire i_clk, // Clock
   input wire i_dout, // Result line
   output reg o_cs_n = 1'b1, // Select
   output reg o_sclk = 1'b0, // Serial clock
   output reg o_din = 1'b0 // Command data
);
   // ----------
   // 2.5 MHz serial clock, inside both rate limits
   // ----------
   task half;
      begin
         repeat (4) @(posedge i_clk);
         #2;
      end
   endtask
   task send(input [8:0] b);
      integer k;
      begin
         o_cs_n = 1'b0;
         for (k = 8; k >= 0; k = k - 1) begin
            o_din = b[k];
            half;
            o_sclk = 1'b1;
            half;
            o_sclk = 1'b0;
         end
         half;
         o_cs_n = 1'b1;
      end
   endtask
   task read(output [15:0] w);
      integer k;
      begin
         o_cs_n = 1'b0;
         o_din = 1'b0;
         for (k = 15; k >= 0; k = k - 1) begin
            half;
            o_sclk = 1'b1;
            half;
            w[k] = i_dout;
            o_sclk = 1'b0;
         end
         half;
         o_cs_n = 1'b1;
      end
   endtask
endmodule

// >>> verification/ascp_properties.sv
`timescale 1ns/1ns
module ascp_properties (
   input wire I_CLK, // Clock
   input wire I_SYS_RST, // Reset
   input wire I_RST_N, // Pin reset
   input wire I_CS_N, // Select
   input wire O_DOUT_OE, // Data enable
   input wire O_STRB, // Strobe
   input wire O_STRB_OE, // Strobe enable
   input wire [2:0] O_GP, // Outputs
   input wire O_CLKSRC, // Clock source
   input wire O_CAL // Calibrate
);
   // ----------
   // Checks
   // ----------
   default clocking @(posedge I_CLK);
   endclocking
   default disable iff (I_SYS_RST);
   gp_reset_a: assert property (
      !I_RST_N [*5] |-> O_GP == 3'h0) else $error("gp not cleared");
   strb_float_a: assert property (
      (!O_CLKSRC && I_CS_N) [*5] |-> !O_STRB_OE) else $error("strb on");
   strb_drive_a: assert property (
      O_CLKSRC [*2] |-> O_STRB_OE) else $error("strb off");
   dout_float_a: assert property (
      I_CS_N [*5] |-> !O_DOUT_OE) else $error("dout on");
   dout_drive_a: assert property (
      !I_CS_N [*5] |-> O_DOUT_OE) else $error("dout off");
   gp_hold_a: assert property (
      (I_CS_N && I_RST_N) [*5] |=> $stable(O_GP)) else $error("gp moved");
   strb_time_a: assert property (
      O_CLKSRC && $fell(O_STRB) |-> ##[1:121] O_STRB)
      else $error("strb low too long");
   cal_pulse_a: assert property (
      O_CAL |=> !O_CAL) else $error("cal too long");
endmodule
bind ascp_top ascp_properties chk_i (.I_CLK, .I_SYS_RST, .I_RST_N,
   .I_CS_N, .O_DOUT_OE, .O_STRB, .O_STRB_OE, .O_GP, .O_CLKSRC, .O_CAL);

// >>> verification/ascp_top_bench.sv
`timescale 1ns/1ns
module ascp_top_bench;
   reg clk = 1'b0;
   reg sys_rst = 1'b1;
   reg rst_n = 1'b1;
   reg shdn_n = 1'b1;
   reg [13:0] res = 14'h0;
   wire cs_n, sclk, din, dout, dout_oe, strb, strb_oe, pol, clksrc, pdown;
   wire [2:0] gp;
   wire line = dout_oe ? dout : 1'bz;
   integer seed = 55532;
   integer fails = 0;
   integer samples_checked = 0;
   integer i;
   integer n;
   reg [7:0] cmd;
   reg [15:0] w;
   reg [15:0] exp_w;
   always #25 clk = ~clk;
   ascp_top uut (.I_CLK(clk), .I_SYS_RST(sys_rst), .I_RST_N(rst_n),
      .I_SHDN_N(shdn_n), .I_CS_N(cs_n), .I_SCLK(sclk), .I_DIN(din),
      .I_RESULT(res), .O_DOUT(dout), .O_DOUT_OE(dout_oe), .O_STRB(strb),
      .O_STRB_OE(strb_oe), .O_GP(gp), .O_POL(pol), .O_CLKSRC(clksrc),
      .O_CAL(), .O_PDOWN(pdown));
   ascp_host host (.i_clk(clk), .i_dout(line), .o_cs_n(cs_n),
      .o_sclk(sclk), .o_din(din));
   task chk(input [15:0] got, input [15:0] want);
      begin
         samples_checked = samples_checked + 1;
         if (got !== want) begin
            fails = fails + 1;
            $display("mismatch at %0t: %h vs %h", $time, got, want);
         end
      end
   endtask
   function [15:0] frame(input [13:0] r);
      frame = {r, 2'h0};
   endfunction
   task tick(input integer c);
      begin
         repeat (c) @(posedge clk);
         #2;
      end
   endtask
   task end_sim;
      begin
         $display("checks %0d fails %0d", samples_checked, fails);
         if (fails == 0 && samples_checked > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   initial begin
      #1000000;
      fails = fails + 1;
      end_sim;
   end
   initial begin
      tick(4);
      sys_rst = 1'b0;
      tick(4);
      chk(16'({gp, pol, clksrc, strb_oe, dout_oe}), 16'h6);
      for (i = 0; i < 8; i = i + 1) begin
         cmd = 8'($random(seed));
         cmd[7] = 1'b1;
         cmd[5] = (i < 6);
         cmd[4:3] = i[1:0];
         res = 14'($random(seed));
         host.send({1'b0, cmd});
         tick(6);
         chk(16'({gp, pol, clksrc}), 16'({cmd[2:0], cmd[6:5]}));
         if (cmd[5]) begin
            n = 0;
            while (strb !== 1'b1 && n < 300) begin
               tick(1);
               n = n + 1;
            end
            chk(16'({strb, strb_oe}), 16'h3);
            // Input moves after completion; the stored word must not
            exp_w = frame(res);
            res = ~res;
            if (cmd[4] == cmd[3]) begin
               host.read(w);
               chk(w, exp_w);
            end
            if (cmd[4:3] == 2'h2)
               chk(16'(pdown), 16'h1);
         end else begin
            shdn_n = 1'b0;
            tick(8);
            chk(16'({gp, strb_oe, dout_oe}), 16'({cmd[2:0], 2'h0}));
            shdn_n = 1'b1;
         end
      end
      host.o_din = 1'b1;
      for (i = 0; i < 16; i = i + 1) begin
         host.o_sclk = ~host.o_sclk;
         tick(4);
      end
      chk(16'(gp), 16'(cmd[2:0]));
      rst_n = 1'b0;
      tick(6);
      chk(16'({gp, pol, clksrc}), 16'h1);
      rst_n = 1'b1;
      tick(4);
      end_sim;
   end
endmodule

// >>> verilog/ascp_sync.v
`timescale 1ns/1ns
// Two-flop synchroniser for pins from outside the clock domain
module ascp_sync #(
   parameter W = 1,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   input wire i_clk,      // System clock
   input wire i_rst,      // Async reset, active high
   input wire [W-1:0] i_d, // Asynchronous input
   output reg [W-1:0] o_q  // Synchronised output
);
   reg [W-1:0] meta;
   // Reset to the pins' idle levels so no false edge follows reset
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta <= INIT;
         o_q <= INIT;
      end else begin
         meta <= i_d;
         o_q <= meta;
      end
   end
endmodule

// >>> verilog/ascp_top.v
`timescale 1ns/1ns
`include "ascp_map.vh"
module ascp_top (
   input wire I_CLK,        // 20 MHz system clock
   input wire I_SYS_RST,    // Async reset, active high
   input wire I_RST_N,      // Hardware reset pin, active low
   input wire I_SHDN_N,     // Hardware shutdown pin, active low; synchronised but drives no logic
   input wire I_CS_N,       // Chip select, active low
   input wire I_SCLK,       // Host serial clock
   input wire I_DIN,        // Serial command input
   input wire [13:0] I_RESULT, // Converter result word
   output reg O_DOUT,       // Serial result output
   output reg O_DOUT_OE,    // Result output enable
   output reg O_STRB,       // Conversion strobe
   output reg O_STRB_OE,    // Strobe output enable
   output reg [2:0] O_GP,   // General-purpose outputs 2..0
   output reg O_POL,        // Polarity select, 1 unipolar
   output reg O_CLKSRC,     // Conversion clock source, 1 internal
   output reg O_CAL,        // Calibration request pulse
   output reg O_PDOWN       // Software power-down level
);
   // ----------------------------------------
   // Pin synchronisation
   // ----------------------------------------
   wire [4:0] pins;
   ascp_sync #(.W(5), .INIT(5'h1c)) u_sync (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .i_d({I_RST_N, I_SHDN_N, I_CS_N, I_SCLK, I_DIN}),
      .o_q(pins)
   );
   wire rst_n_s = pins[4];
   wire cs_n_s = pins[2];
   wire sclk_s = pins[1];
   wire din_s = pins[0];
   reg sclk_d;
   reg cs_d;
   wire sclk_rise = sclk_s & ~sclk_d & ~cs_n_s;
   wire sclk_fall = ~sclk_s & sclk_d & ~cs_n_s;
   wire cs_fall = ~cs_n_s & cs_d;

   localparam ST_IDLE = 4'h1;
   localparam ST_CMD = 4'h2;
   localparam ST_CONV = 4'h4;
   localparam ST_OUT = 4'h8;
   reg [3:0] state;
   reg [2:0] bit_cnt;
   reg [6:0] shreg;
   reg [5:0] edge_cnt;
   reg [5:0] edge_end;
   reg [7:0] conv_cnt;
   reg [15:0] result;
   reg [4:0] out_cnt;
   reg armed;
   wire [7:0] cmd = {shreg, din_s};

   function is_long;
      input [1:0] m;
      begin
         is_long = (m == `ASCP_MODE_LONG);
      end
   endfunction

   // ----------------------------------------
   // Command, conversion and readout
   // ----------------------------------------
   always @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         sclk_d <= 1'b0;
         cs_d <= 1'b1;
         state <= ST_IDLE;
         bit_cnt <= 3'h0;
         shreg <= 7'h0;
         edge_cnt <= 6'h0;
         edge_end <= 6'h0;
         conv_cnt <= 8'h0;
         result <= 16'h0;
         out_cnt <= 5'h0;
         armed <= 1'b1;
         O_DOUT <= 1'b0;
         O_DOUT_OE <= 1'b0;
         O_STRB <= 1'b0;
         O_STRB_OE <= 1'b1;
         O_GP <= `ASCP_GP_RESET;
         O_POL <= `ASCP_POL_RESET;
         O_CLKSRC <= `ASCP_CLKSRC_RESET;
         O_CAL <= 1'b0;
         O_PDOWN <= 1'b0;
      end else if (!rst_n_s) begin
         // Pin reset returns state and outputs to power-on values, except O_DOUT
         state <= ST_IDLE;
         armed <= 1'b1;
         O_GP <= `ASCP_GP_RESET;
         O_POL <= `ASCP_POL_RESET;
         O_CLKSRC <= `ASCP_CLKSRC_RESET;
         O_STRB <= 1'b0;
         O_CAL <= 1'b0;
         O_PDOWN <= 1'b0;
         O_DOUT_OE <= 1'b0;
         O_STRB_OE <= 1'b1;
      end else begin
         sclk_d <= sclk_s;
         cs_d <= cs_n_s;
         O_CAL <= 1'b0;
         O_DOUT_OE <= ~cs_n_s;
         O_STRB_OE <= O_CLKSRC | ~cs_n_s;
         if (cs_fall)
            armed <= 1'b1;
         case (state)
            ST_IDLE: begin
               if (sclk_rise && din_s && armed) begin
                  state <= ST_CMD;
                  bit_cnt <= 3'h0;
                  shreg <= 7'h1;
                  armed <= 1'b0;
               end
            end
            ST_CMD: begin
               if (sclk_rise) begin
                  shreg <= {shreg[5:0], din_s};
                  bit_cnt <= bit_cnt + 3'h1;
                  if (bit_cnt == 3'h6) begin
                     // Gp bits all update in one cycle
                     O_GP <= cmd[`ASCP_BIT_GP2:`ASCP_BIT_GP0];
                     O_POL <= cmd[`ASCP_BIT_POL];
                     O_CLKSRC <= cmd[`ASCP_BIT_CLKSRC];
                     O_PDOWN <= 1'b0;
                     edge_cnt <= 6'h0;
                     edge_end <= is_long(cmd[4:3]) ?
                        `ASCP_STROBE_LONG_EDGE : `ASCP_STROBE_SHORT_EDGE;
                     conv_cnt <= 8'h0;
                     case (cmd[4:3])
                        `ASCP_MODE_PDOWN: begin
                           O_PDOWN <= 1'b1;
                           state <= ST_IDLE;
                        end
                        `ASCP_MODE_CAL: begin
                           O_CAL <= 1'b1;
                           state <= ST_CONV;
                           O_STRB <= ~cmd[`ASCP_BIT_CLKSRC];
                        end
                        default: begin
                           state <= ST_CONV;
                           O_STRB <= 1'b0;
                        end
                     endcase
                  end
               end
            end
            ST_CONV: begin
               if (O_CLKSRC) begin
                  // Runs on regardless of select
                  conv_cnt <= conv_cnt + 8'h1;
                  if (conv_cnt == `ASCP_CONV_CYCLES - 1) begin
                     result <= {I_RESULT, 2'h0};
                     O_DOUT <= I_RESULT[13];
                     O_STRB <= 1'b1;
                     out_cnt <= 5'h0;
                     armed <= 1'b1;
                     state <= ST_OUT;
                  end
               end else begin
                  O_STRB <= 1'b0;
                  if (sclk_fall) begin
                     edge_cnt <= edge_cnt + 6'h1;
                     if (edge_cnt == edge_end - 6'h1)
                        O_STRB <= 1'b1;
                     if (edge_cnt == edge_end) begin
                        result <= {I_RESULT, 2'h0};
                        O_DOUT <= I_RESULT[13];
                        out_cnt <= 5'h0;
                        armed <= 1'b1;
                        state <= ST_OUT;
                     end
                  end
               end
            end
            ST_OUT: begin
               if (!O_CLKSRC)
                  O_STRB <= 1'b0;
               if (sclk_fall) begin
                  result <= {result[14:0], 1'b0};
                  O_DOUT <= result[14];
                  out_cnt <= out_cnt + 5'h1;
                  if (out_cnt == `ASCP_RESULT_BITS - 2)
                     state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
         // Reselect alone aborts nothing; only a fresh start bit does,
         // so a split frame or a late readout survives deselect
         if (state != ST_IDLE && state != ST_CMD && sclk_rise && din_s &&
             armed) begin
            state <= ST_CMD;
            bit_cnt <= 3'h0;
            shreg <= 7'h1;
            armed <= 1'b0;
         end
      end
   end
endmodule
